// ===== test/mcob_modem_model.sv
// behavioural modem on the far side of the control output byte
module mcob_modem_model (
	input  wire logic                clk,
	input  wire mcob_pkg::mcob_ctl_t modem,
	input  wire logic                tx_active,
	output int                       poll_width,
	output logic                     on_line
);
	timeunit 1ns;
	timeprecision 1ps;
	import mcob_pkg::*;
	int   run     = 0;
	int   width_q = 0;
	logic line_q  = 1'b0;
	assign poll_width = width_q;
	assign on_line    = line_q;
	// band select is never looked at here
	always @(posedge clk) begin
		// stays on line while terminal ready; data still being sent keeps it there
		line_q <= modem.terminal_ready || (line_q && tx_active);
		if (modem.polling) begin
			run <= run + 1;
		end else if (run != 0) begin
			width_q <= run;
			run <= 0;
		end
	end
endmodule : mcob_modem_model

// ===== test/modem_control_output_byte_test.sv
// self-checking bench of the modem control output byte
module modem_control_output_byte_test;
	timeunit 1ns;
	timeprecision 1ps;
	import mcob_pkg::*;
	logic       clk;
	logic       reset_n;
	mcob_cmd_t  cmd;
	mcob_mode_t mode;
	logic       expect_msg;
	logic       rts;
	logic       tx_active;
	logic [7:0] rd_data;
	logic       rd_valid;
	mcob_ctl_t  modem;
	logic       rx_enable;
	int         poll_width;
	logic       on_line;
	int         n_mismatch;
	int         check_count;

	mcob_ctl DUT (.clk(clk), .reset_n(reset_n), .cmd(cmd), .mode(mode),
		.expect_msg(expect_msg), .rts(rts), .tx_active(tx_active), .rd_data(rd_data),
		.rd_valid(rd_valid), .modem(modem), .rx_enable(rx_enable));
	mcob_modem_model partner (.clk(clk), .modem(modem), .tx_active(tx_active),
		.poll_width(poll_width), .on_line(on_line));

	// ---------------------------------------------------------
	// tasks
	// ---------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] d);
		cmd.wr = 1'b1;
		cmd.wr_data = d;
		@(negedge clk);
		cmd.wr = 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic md(input logic hd, input logic cs);
		mode = '{valid: 1'b1, half_duplex: hd, control_station: cs};
		@(negedge clk);
		mode.valid = 1'b0;
		@(negedge clk);
	endtask : md
	task automatic rd(input logic [7:0] exp);
		int k;
		cmd.rd = 1'b1;
		@(negedge clk);
		cmd.rd = 1'b0;
		for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(negedge clk);
		if (k == 4) begin
			n_mismatch++;
			stop_test();
		end
		check(16'(rd_data), 16'(exp), "read back");
	endtask : rd
	task automatic rx(input logic r, input logic t, input logic exp);
		@(negedge clk);
		rts = r;
		tx_active = t;
		#1 check(16'(rx_enable), 16'(exp), "receiver enable");
	endtask : rx
	task automatic wait_poll();
		int k;
		for (k = 0; k < 600 && modem.polling !== 1'b0; k++) @(negedge clk);
		if (k == 600) begin
			n_mismatch++;
			stop_test();
		end
		@(negedge clk);
	endtask : wait_poll

	// ---------------------------------------------------------
	// sequence
	// ---------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		n_mismatch = 0;
		check_count = 0;
		reset_n = 1'b0;
		cmd = '0;
		mode = '0;
		expect_msg = 1'b0;
		rts = 1'b0;
		tx_active = 1'b0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		check(16'(modem), 16'(CTL_RESET), "modem after reset");
		rd(8'h00);
		wr(8'hff);
		rd(8'h6e);
		check(16'(on_line), 16'h1, "modem on line");
		md(1'b1, 1'b0);
		rd(8'h7e);
		tx_active = 1'b1;
		wr(8'h00);
		check(16'(on_line), 16'h1, "modem hung up while sending");
		tx_active = 1'b0;
		@(negedge clk);
		check(16'(on_line), 16'h0, "modem still on line");
		rd(8'h10);
		rx(1'b1, 1'b0, 1'b0);
		rx(1'b0, 1'b1, 1'b0);
		rx(1'b0, 1'b0, 1'b1);
		@(negedge clk);
		expect_msg = 1'b1;
		@(negedge clk);
		expect_msg = 1'b0;
		repeat (2) @(negedge clk);
		check(16'(modem.polling), 16'h0, "polling off a tributary");
		md(1'b0, 1'b1);
		rx(1'b1, 1'b0, 1'b1);
		@(negedge clk);
		expect_msg = 1'b1;
		@(negedge clk);
		expect_msg = 1'b0;
		check(16'(modem.polling), 16'h0, "polling too early");
		@(negedge clk);
		check(16'(modem.polling), 16'h1, "polling raised");
		wait_poll();
		check(16'(poll_width), 16'(POLL_CYCLES), "polling width");
		rd(8'h00);
		wr(8'h80);
		check(16'(modem.polling), 16'h1, "polling by write");
		wr(8'h80);
		wait_poll();
		check(16'(poll_width), 16'(POLL_CYCLES), "polling width on retrigger");
		stop_test();
	end
endmodule : modem_control_output_byte_test

// ===== verilog/mcob_ctl.sv
// modem control output byte with half-duplex receive interlock
// How it works
// RL1 - standby and both maintenance selects reset to zero.
// RL2 - half-duplex bit ignores software writes; only the device changes it.
// RL3 - line characteristics change only on a mode definition command.
// RL4 - in half-duplex, receiver is off while the transmitter sends.
// RL5 - bit 5 drives band select: on means high transmit, low receive band.
// RL6 - a band-selecting modem must be set to ignore that output.
// RL7 - bit 6 drives terminal ready, holding the modem on the line.
// RL8 - on terminal ready off, the modem drains sent data before hanging up.
// RL9 - control station pulses polling briefly before an expected message.
// RL10 - bit 0 ignores writes and reads as zero.
// RL11 - request to send AND half-duplex blinds the receiver.
module mcob_ctl (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire mcob_pkg::mcob_cmd_t  cmd,
	input  wire mcob_pkg::mcob_mode_t mode,
	input  wire logic                 expect_msg,
	input  wire logic                 rts,
	input  wire logic                 tx_active,
	output logic [7:0]                rd_data,
	output logic                      rd_valid,
	output mcob_pkg::mcob_ctl_t       modem,
	output logic                      rx_enable
);
	import mcob_pkg::*;

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		mcob_ctl_t  ctl;
		logic       control_station;
		logic [7:0] rd_data;
		logic       rd_valid;
	} mcob_state_t;

	mcob_state_t state;
	mcob_state_t next_state;
	logic        poll_start;
	logic        poll_busy;
	logic        tx_busy;

	// -------------------------------------------------------------
	// polling pulse
	// -------------------------------------------------------------
	// at a control station, a software write of bit 7 or an expected-message strobe asks for a poll
	assign poll_start = state.control_station &&
		(expect_msg || (cmd.wr && cmd.wr_data[BIT_POLLING])); // RL9

	mcob_pulse_timer #(
		.CYCLES (POLL_CYCLES)
	) u_poll (
		.clk     (clk),
		.reset_n (reset_n),
		.start   (poll_start),
		.busy    (poll_busy)
	);

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		next_state          = state;
		next_state.rd_valid = 1'b0;
		if (cmd.wr) begin
			next_state.ctl.standby        = cmd.wr_data[BIT_STANDBY];
			next_state.ctl.maint2         = cmd.wr_data[BIT_MAINT2];
			next_state.ctl.maint1         = cmd.wr_data[BIT_MAINT1];
			next_state.ctl.select_freq    = cmd.wr_data[BIT_FREQ_SEL]; // RL5
			next_state.ctl.terminal_ready = cmd.wr_data[BIT_TERM_RDY]; // RL7
		end
		// half-duplex and station role are only taken from a mode definition
		if (mode.valid) begin
			next_state.ctl.half_duplex = mode.half_duplex; // RL2 RL3
			next_state.control_station = mode.control_station; // RL3
		end
		next_state.ctl.polling = poll_busy; // RL9
		next_state.ctl.unused  = 1'b0; // RL10
		if (cmd.rd) begin
			next_state.rd_data  = state.ctl;
			next_state.rd_data[BIT_UNUSED] = 1'b0; // RL10
			next_state.rd_valid = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '{ctl: mcob_ctl_t'(CTL_RESET), control_station: 1'b0,
				rd_data: 8'h00, rd_valid: 1'b0}; // RL1
		end else begin
			state <= next_state;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign modem    = state.ctl;
	assign rd_data  = state.rd_data;
	assign rd_valid = state.rd_valid;
	// the band-select line goes out even though the modem may ignore it
	assign tx_busy   = rts || tx_active;
	assign rx_enable = !(state.ctl.half_duplex && tx_busy); // RL4 RL11

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	logic [POLL_CW:0] poll_len;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			poll_len <= '0;
		end else if (state.ctl.polling) begin
			poll_len <= poll_len + (POLL_CW+1)'(1);
		end else begin
			poll_len <= '0;
		end
	end

	chk_reset_defaults: assert property (@(posedge clk) disable iff (!reset_n) // RL1
		!$past(reset_n) |-> !modem.standby && !modem.maint1 && !modem.maint2)
		else $error("selects not zero after reset");

	chk_write_keeps_hd: assert property (@(posedge clk) disable iff (!reset_n) // RL2
		cmd.wr && !mode.valid |=> modem.half_duplex == $past(modem.half_duplex))
		else $error("write changed half-duplex");

	chk_hd_by_mode: assert property (@(posedge clk) disable iff (!reset_n) // RL3
		$changed(modem.half_duplex) |-> $past(mode.valid))
		else $error("half-duplex changed without mode definition");

	chk_rx_blinded: assert property (@(posedge clk) disable iff (!reset_n) // RL4
		modem.half_duplex && tx_active |-> !rx_enable)
		else $error("receiver open while sending in half-duplex");

	chk_rts_and_hd: assert property (@(posedge clk) disable iff (!reset_n) // RL11
		rx_enable == !(modem.half_duplex && (rts || tx_active)))
		else $error("receive interlock wrong");

	chk_band_follows: assert property (@(posedge clk) disable iff (!reset_n) // RL5
		cmd.wr |=> modem.select_freq == $past(cmd.wr_data[5]))
		else $error("band select not written");

	chk_ready_follows: assert property (@(posedge clk) disable iff (!reset_n) // RL7
		cmd.wr ##1 !cmd.wr |=> modem.terminal_ready == $past(cmd.wr_data[6], 2))
		else $error("terminal ready not held");

	chk_poll_cause: assert property (@(posedge clk) disable iff (!reset_n) // RL9
		$rose(modem.polling) |-> $past(state.control_station, 2) &&
			$past(expect_msg || (cmd.wr && cmd.wr_data[7]), 2))
		else $error("polling without station request");

	chk_poll_length: assert property (@(posedge clk) disable iff (!reset_n) // RL9
		$fell(modem.polling) |-> $past(poll_len) == (POLL_CW+1)'(POLL_CYCLES - 1))
		else $error("polling pulse length wrong");

	chk_bit0_zero: assert property (@(posedge clk) disable iff (!reset_n) // RL10
		rd_valid |-> !rd_data[0] && !modem.unused)
		else $error("unused bit not zero");

	chk_read_shows: assert property (@(posedge clk) disable iff (!reset_n) // RL2
		cmd.rd |=> rd_valid && rd_data[4] == $past(modem.half_duplex))
		else $error("read does not show half-duplex");

	chk_read_whole: assert property (@(posedge clk) disable iff (!reset_n) // RL10
		cmd.rd |=> rd_data[7:1] == $past(modem[7:1]))
		else $error("read does not show the byte");

	chk_read_pulse: assert property (@(posedge clk) disable iff (!reset_n) // RL10
		!cmd.rd |=> !rd_valid)
		else $error("read valid without read");

	chk_unused_low: assert property (@(posedge clk) disable iff (!reset_n) // RL10
		!modem.unused)
		else $error("unused output bit set");

	// -------------------------------------------------------------
	// checks: written bits
	// -------------------------------------------------------------
	chk_selects_written: assert property (@(posedge clk) disable iff (!reset_n) // RL1
		cmd.wr |=> {modem.maint1, modem.maint2, modem.standby} ==
			$past(cmd.wr_data[BIT_MAINT1:BIT_STANDBY]))
		else $error("selects not written");

	chk_selects_hold: assert property (@(posedge clk) disable iff (!reset_n) // RL1
		!cmd.wr |=> $stable({modem.maint1, modem.maint2, modem.standby}))
		else $error("selects changed without write");

	chk_band_holds: assert property (@(posedge clk) disable iff (!reset_n) // RL5
		!cmd.wr |=> $stable(modem.select_freq))
		else $error("band select changed without write");

	chk_ready_written: assert property (@(posedge clk) disable iff (!reset_n) // RL7
		cmd.wr |=> modem.terminal_ready == $past(cmd.wr_data[BIT_TERM_RDY]))
		else $error("terminal ready not written");

	chk_ready_holds: assert property (@(posedge clk) disable iff (!reset_n) // RL7
		!cmd.wr |=> $stable(modem.terminal_ready))
		else $error("terminal ready changed without write");

	// -------------------------------------------------------------
	// checks: mode and receive interlock
	// -------------------------------------------------------------
	chk_hd_from_mode: assert property (@(posedge clk) disable iff (!reset_n) // RL3
		mode.valid |=> modem.half_duplex == $past(mode.half_duplex))
		else $error("half-duplex not taken from mode definition");

	chk_role_from_mode: assert property (@(posedge clk) disable iff (!reset_n) // RL3
		!mode.valid |=> $stable(state.control_station))
		else $error("station role changed without mode definition");

	chk_rx_open: assert property (@(posedge clk) disable iff (!reset_n) // RL11
		!modem.half_duplex |-> rx_enable)
		else $error("receiver closed in full duplex");

	chk_rts_blinds: assert property (@(posedge clk) disable iff (!reset_n) // RL11
		modem.half_duplex && rts |-> !rx_enable)
		else $error("receiver open while requesting to send");

	// -------------------------------------------------------------
	// checks: polling
	// -------------------------------------------------------------
	chk_poll_starts: assert property (@(posedge clk) disable iff (!reset_n) // RL9
		state.control_station && expect_msg && !poll_busy |-> ##2 modem.polling)
		else $error("expected message gave no polling pulse");

	chk_poll_gated: assert property (@(posedge clk) disable iff (!reset_n) // RL9
		!state.control_station && !poll_busy |=> !poll_busy)
		else $error("polling started away from control station");

endmodule : mcob_ctl

// ===== verilog/mcob_pkg.sv
// shared types and constants of the modem control output byte
package mcob_pkg;

	// -------------------------------------------------------------
	// byte layout
	// -------------------------------------------------------------
	localparam int unsigned BIT_UNUSED   = 0;
	localparam int unsigned BIT_STANDBY  = 1;
	localparam int unsigned BIT_MAINT2   = 2;
	localparam int unsigned BIT_MAINT1   = 3;
	localparam int unsigned BIT_HALF_DPX = 4;
	localparam int unsigned BIT_FREQ_SEL = 5;
	localparam int unsigned BIT_TERM_RDY = 6;
	localparam int unsigned BIT_POLLING  = 7;

	localparam logic [7:0] CTL_RESET = 8'h00;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int unsigned CLK_MHZ      = 50;
	localparam int unsigned POLL_TIME_NS = 10000;
	// least time, so rounded up to whole cycles
	localparam int unsigned POLL_CYCLES  = (POLL_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned POLL_CW      = 10;

	// -------------------------------------------------------------
	// carriers
	// -------------------------------------------------------------
	// bit order follows the byte, bit 7 first
	typedef struct packed {
		logic polling;
		logic terminal_ready;
		logic select_freq;
		logic half_duplex;
		logic maint1;
		logic maint2;
		logic standby;
		logic unused;
	} mcob_ctl_t;

	// write / read of the modem control output byte by the control command
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] wr_data;
	} mcob_cmd_t;

	// mode definition command
	typedef struct packed {
		logic valid;
		logic half_duplex;
		logic control_station;
	} mcob_mode_t;

endpackage : mcob_pkg

// ===== verilog/mcob_pulse_timer.sv
// fixed-length pulse generator, ignores starts while running
module mcob_pulse_timer #(
	parameter int unsigned CYCLES = 1
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      busy
);
	import mcob_pkg::*;

	localparam logic [POLL_CW-1:0] LAST = POLL_CW'(CYCLES - 1);

	typedef struct packed {
		logic               run;
		logic [POLL_CW-1:0] count;
	} mcob_tmr_t;

	mcob_tmr_t state;
	mcob_tmr_t next_state;

	always_comb begin
		next_state = state;
		if (state.run) begin
			if (state.count == LAST) begin
				next_state.run   = 1'b0;
				next_state.count = '0;
			end else begin
				next_state.count = state.count + POLL_CW'(1);
			end
		end else if (start) begin
			next_state.run   = 1'b1;
			next_state.count = '0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign busy = state.run;

endmodule : mcob_pulse_timer
